// ===== dv/mio_host_model.sv
`timescale 1ns/10ps

// ==========================================================
// SPI host, mode 0: sclk low outside frames
module mio_host_model (
	input wire logic ref_clk,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] lanes
);
	logic [3:0] drv;
	logic hoe;
	logic [3:0] junk;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
		hoe = 1'b0;
		junk = 4'h5;
	end

	// Released lanes toggle so a stale value never looks valid
	always @(posedge ref_clk) junk <= ~junk;
	assign lanes = (dev_oe & dev_out) | (~dev_oe & (hoe ? drv : junk));

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// Keeps cs high two sclk periods between frames
	task select(input logic lvl);
		tick(8);
		cs_n = lvl;
		tick(8);
	endtask : select

	task send(input logic [31:0] v, input int nbits, input int nl, input bit dtr);
		logic [31:0] sh;
		sh = v << (32 - nbits);
		hoe = 1'b1;
		for (int k = 0; k < nbits; k += nl) begin
			drv = sh[31:28] >> (4 - nl);
			sh = sh << nl;
			tick(2);
			sclk = 1'b1;
			tick(2);
			if (dtr) begin
				k += nl;
				drv = sh[31:28] >> (4 - nl);
				sh = sh << nl;
			end else if (k + nl >= nbits) begin
				hoe = 1'b0;
			end
			tick(2);
			sclk = 1'b0;
			tick(2);
		end
	endtask : send

	task dummy(input int n);
		hoe = 1'b0;
		repeat (n) begin
			tick(2);
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
			tick(2);
		end
	endtask : dummy

	// Samples just before each used edge, where the last lane value has settled
	task recv(input int nl, input bit dtr, output logic [7:0] b);
		b = 8'h00;
		for (int k = 0; k < 8; k += nl) begin
			tick(2);
			if (dtr) begin
				b = (b << nl) | 8'(lanes & ((4'h1 << nl) - 4'h1));
				k += nl;
			end
			sclk = 1'b1;
			tick(4);
			b = (b << nl) | 8'(lanes & ((4'h1 << nl) - 4'h1));
			sclk = 1'b0;
			tick(2);
		end
	endtask : recv
endmodule : mio_host_model

// ===== dv/mio_read_seq_tb.sv
`timescale 1ns/10ps

module mio_read_seq_tb import mio_pkg::*; ;
	logic ref_clk;
	logic reset;
	mio_cfg_t cfg;
	logic cs_n_pin;
	logic sclk_pin;
	logic [3:0] lanes;
	logic [3:0] data_lane_out_q;
	logic [3:0] data_lane_oe_q;
	logic fetch_req_q;
	logic [31:0] fetch_addr_q;
	logic arr_valid;
	logic [7:0] arr_data;
	logic continuous_read_q;
	logic reject_q;
	logic busy_q;
	logic underrun_q;
	logic got_req, seen_rej, seen_oe, seen_under, exp_cont;
	logic [31:0] first_addr;
	int lat, wait_n, cyc, errors, checks;
	logic [7:0] ops [5] = '{8'h6c, 8'hbb, 8'hbd, 8'hbc, 8'heb};

	mio_read_seq #(.FIFO_DEPTH(8)) u_mio_read_seq (.ref_clk(ref_clk), .reset(reset),
		.cfg(cfg), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .data_lane_in(lanes),
		.data_lane_out_q(data_lane_out_q), .data_lane_oe_q(data_lane_oe_q),
		.fetch_req_q(fetch_req_q), .fetch_addr_q(fetch_addr_q), .arr_valid(arr_valid),
		.arr_data(arr_data), .continuous_read_q(continuous_read_q), .reject_q(reject_q),
		.busy_q(busy_q), .underrun_q(underrun_q));

	mio_host_model u_mio_host_model (.ref_clk(ref_clk), .dev_out(data_lane_out_q),
		.dev_oe(data_lane_oe_q), .cs_n(cs_n_pin), .sclk(sclk_pin), .lanes(lanes));

	function automatic logic [7:0] pat(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction : pat

	always #20 ref_clk = ~ref_clk;

	// ==========================================================
	// Array model with adjustable latency
	always @(posedge ref_clk) begin
		#1;
		arr_valid = 1'b0;
		if (wait_n > 0) begin
			wait_n--;
			if (wait_n == 0) begin
				arr_valid = 1'b1;
				arr_data = pat(fetch_addr_q);
			end
		end
		if (fetch_req_q === 1'b1) wait_n = lat;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (fetch_req_q === 1'b1 && !got_req) begin
			got_req <= 1'b1;
			first_addr <= fetch_addr_q;
		end
		if (reject_q === 1'b1) seen_rej <= 1'b1;
		if (underrun_q === 1'b1) seen_under <= 1'b1;
		if (data_lane_oe_q !== 4'h0) seen_oe <= 1'b1;
		if (cyc == 20000) begin
			errors++;
			conclude();
		end
	end

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// ==========================================================
	// One read frame, laid out from the opcode's lane and width rules
	task frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] m,
		input int nb, input logic rej);
		int aw, al, dm, dl;
		logic dtr;
		logic [7:0] b;
		logic [31:0] ea;
		aw = (op == 8'h6c || op == 8'hbc || cfg.four_byte_mode) ? 32 : 24;
		al = (op == 8'h6c) ? 1 : ((op == 8'heb) ? 4 : 2);
		dtr = (op == 8'hbd);
		dm = (op == 8'h6c) ? 8 : ((op == 8'hbb || op == 8'hbc) ? 0 : 4);
		dl = (op == 8'h6c || op == 8'heb) ? 4 : 2;
		ea = (aw == 24) ? {8'h00, a[23:0]} : a;
		got_req = 1'b0;
		seen_rej = 1'b0;
		seen_oe = 1'b0;
		seen_under = 1'b0;
		u_mio_host_model.select(1'b0);
		if (!exp_cont) u_mio_host_model.send(op, 8, cfg.quad_command_mode ? 4 : 1, 1'b0);
		u_mio_host_model.send(a, aw, al, dtr);
		if (op != 8'h6c) u_mio_host_model.send(m, 8, al, dtr);
		u_mio_host_model.dummy(dm);
		for (int i = 0; i < nb; i++) begin
			u_mio_host_model.recv(dl, dtr, b);
			check("data", (lat > 50) ? 8'hff : pat(ea + i), b);
			check("lane enable", (dl == 4) ? 4'hf : 4'h3, data_lane_oe_q);
		end
		check("busy", 1'b1, busy_q);
		u_mio_host_model.select(1'b1);
		check("busy", 1'b0, busy_q);
		check("reject", rej, seen_rej);
		check("lanes driven", !rej, seen_oe);
		check("underrun", nb > 0 && lat > 50, seen_under);
		if (!rej) begin
			exp_cont = (m[5:4] == 2'b10);
			check("fetch address", ea, first_addr);
			check("fetch issued", 1'b1, got_req);
		end
		check("continuous", exp_cont, continuous_read_q);
		$display("test op %h done, errors %0d", op, errors);
	endtask : frame

	task conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		cfg = 3'b100;
		arr_valid = 1'b0;
		arr_data = 8'h00;
		lat = 2;
		wait_n = 0;
		cyc = 0;
		errors = 0;
		checks = 0;
		exp_cont = 1'b0;
		got_req = 1'b0;
		u_mio_host_model.tick(5);
		reset = 1'b0;
		u_mio_host_model.tick(3);
		frame(8'heb, 32'h00123456, 8'h2f, 3, 1'b0);
		frame(8'heb, 32'h00ffffff, 8'hff, 2, 1'b0);
		frame(8'heb, 32'h00000010, 8'h00, 1, 1'b0);
		cfg.quad_lane_enable_bit = 1'b0;
		frame(8'heb, 32'h00000100, 8'h00, 0, 1'b1);
		cfg.quad_lane_enable_bit = 1'b1;
		cfg.quad_command_mode = 1'b1;
		foreach (ops[i]) frame(ops[i], 32'h00000200, 8'h00, 0, ops[i] != 8'heb);
		cfg.quad_command_mode = 1'b0;
		frame(8'h6c, 32'h01234567, 8'h00, 2, 1'b0);
		frame(8'hbc, 32'h0200abcd, 8'h00, 2, 1'b0);
		cfg.four_byte_mode = 1'b1;
		frame(8'hbb, 32'h03000010, 8'h20, 2, 1'b0);
		cfg.four_byte_mode = 1'b0;
		frame(8'hbb, 32'hffffffff, 8'hff, 0, 1'b0);
		frame(8'hbd, 32'h00345678, 8'h20, 2, 1'b0);
		frame(8'hbd, 32'hffffffff, 8'hff, 0, 1'b0);
		lat = 120;
		frame(8'heb, 32'h00000777, 8'h00, 1, 1'b0);
		conclude();
	end
endmodule : mio_read_seq_tb

// ===== rtl/mio_consts.svh
`ifndef MIO_CONSTS_SVH
`define MIO_CONSTS_SVH

// ==========================================================
// Opcodes
`define MIO_OP_QO_W32 8'h6c
`define MIO_OP_DIO 8'hbb
`define MIO_OP_DIO_DTR 8'hbd
`define MIO_OP_DIO_W32 8'hbc
`define MIO_OP_QIO 8'heb

// ==========================================================
// Phase lengths, in bits or clocks
`define MIO_OPCODE_BITS 6'h08
`define MIO_MODE_BITS 6'h08
`define MIO_ADDR_NARROW 6'h18
`define MIO_ADDR_WIDE 6'h20
`define MIO_DUMMY_QO 6'h08
`define MIO_DUMMY_DIO 6'h00
`define MIO_DUMMY_DIO_DTR 6'h04
`define MIO_DUMMY_QIO 6'h04

// ==========================================================
// Continuous read select field and fill values
`define MIO_CONT_SEL 2'h2
`define MIO_CONT_SEL_MSB 5
`define MIO_CONT_SEL_LSB 4
`define MIO_UNDERRUN_BYTE 8'hff
`define MIO_PIN_INIT 6'h20

`endif

// ===== rtl/mio_fifo.sv
`timescale 1ns/10ps

module mio_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// DEPTH must be a power of two for the wrap bit to work
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;

	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (in_valid && !full && !flush) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || flush) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule : mio_fifo

// ===== rtl/mio_pkg.sv
package mio_pkg;

	typedef enum logic [2:0] {
		mio_st_idle = 3'b000,
		mio_st_cmd = 3'b001,
		mio_st_addr = 3'b010,
		mio_st_mode = 3'b011,
		mio_st_dummy = 3'b100,
		mio_st_data = 3'b101,
		mio_st_ignore = 3'b110
	} mio_state_t;

	typedef struct packed {
		logic quad_lane_enable_bit;
		logic quad_command_mode;
		logic four_byte_mode;
	} mio_cfg_t;

	typedef struct packed {
		logic valid;
		logic [2:0] addr_lanes;
		logic [2:0] data_lanes;
		logic dtr;
		logic has_mode;
		logic [5:0] dummy;
		logic [5:0] addr_bits;
	} mio_op_info_t;

endpackage : mio_pkg

// ===== rtl/mio_read_seq.sv
// Behaviour
// - Opcode 6Ch always takes 32 address bits
// - Opcode 6Ch refused in quad command mode
// - Dual I/O address arrives two bits per clock
// - Dual I/O: no dummy clocks; DTR dual I/O four, lane input ignored
// - Mode byte follows address; low nibble ignored
// - Select bits 10: next frame skips opcode
// - Other select values: next frame needs opcode
// - Opcode BCh always takes 32 address bits
// - Opcode BCh refused in quad command mode
// - Quad I/O: four lanes, four dummy clocks
// - Quad I/O refused without quad lane enable
// - Address 24 bits, or 32 in four-byte mode
// - DTR reads use both clock edges
// - Address advances per byte until deselect
`timescale 1ns/10ps
`include "mio_consts.svh"

module mio_read_seq import mio_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire mio_cfg_t cfg,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic [3:0] data_lane_in,
	output logic [3:0] data_lane_out_q,
	output logic [3:0] data_lane_oe_q,
	output logic fetch_req_q,
	output logic [31:0] fetch_addr_q,
	input wire logic arr_valid,
	input wire logic [7:0] arr_data,
	output logic continuous_read_q,
	output logic reject_q,
	output logic busy_q,
	output logic underrun_q
);
	// ==========================================================
	// Opcode decode
	function automatic mio_op_info_t op_info(input logic [7:0] op, input logic four_b);
		mio_op_info_t i;
		i = '0;
		i.addr_bits = four_b ? `MIO_ADDR_WIDE : `MIO_ADDR_NARROW;
		case (op)
			`MIO_OP_QO_W32: begin
				i.valid = 1'b1;
				i.addr_lanes = 3'h1;
				i.data_lanes = 3'h4;
				i.dummy = `MIO_DUMMY_QO;
				i.addr_bits = `MIO_ADDR_WIDE;
			end
			`MIO_OP_DIO, `MIO_OP_DIO_W32: begin
				i.valid = 1'b1;
				i.addr_lanes = 3'h2;
				i.data_lanes = 3'h2;
				i.has_mode = 1'b1;
				i.dummy = `MIO_DUMMY_DIO;
				if (op == `MIO_OP_DIO_W32) begin
					i.addr_bits = `MIO_ADDR_WIDE;
				end
			end
			`MIO_OP_DIO_DTR: begin
				i.valid = 1'b1;
				i.addr_lanes = 3'h2;
				i.data_lanes = 3'h2;
				i.dtr = 1'b1;
				i.has_mode = 1'b1;
				i.dummy = `MIO_DUMMY_DIO_DTR;
			end
			`MIO_OP_QIO: begin
				i.valid = 1'b1;
				i.addr_lanes = 3'h4;
				i.data_lanes = 3'h4;
				i.has_mode = 1'b1;
				i.dummy = `MIO_DUMMY_QIO;
			end
			default: begin
				i.valid = 1'b0;
			end
		endcase
		return i;
	endfunction : op_info

	// Top bits of a byte on the lowest lanes, upper group first
	function automatic logic [3:0] lanes_of(input logic [7:0] b, input logic [2:0] w);
		case (w)
			3'h4: lanes_of = b[7:4];
			3'h2: lanes_of = {2'h0, b[7:6]};
			default: lanes_of = 4'h0;
		endcase
	endfunction : lanes_of

	// ==========================================================
	// Pin sampling and edge finding
	logic [5:0] pin_s;
	logic s_cs_n;
	logic s_sclk;
	logic [3:0] s_io;
	logic sclk_prev_q;
	logic cs_prev_q;
	logic rise;
	logic fall;
	logic cs_fall;

	mio_sync #(.WIDTH(6), .INIT(`MIO_PIN_INIT)) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.async_in({cs_n_pin, sclk_pin, data_lane_in}),
		.sync_out(pin_s)
	);

	assign s_cs_n = pin_s[5];
	assign s_sclk = pin_s[4];
	assign s_io = pin_s[3:0];
	assign rise = s_sclk && !sclk_prev_q;
	assign fall = !s_sclk && sclk_prev_q;
	assign cs_fall = !s_cs_n && cs_prev_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= s_sclk;
			cs_prev_q <= s_cs_n;
		end
	end

	// ==========================================================
	// Sequencer state
	mio_state_t st_q;
	logic [5:0] cnt_q;
	logic [31:0] sh_q;
	logic [7:0] op_q;
	mio_op_info_t info_q;
	logic [7:0] mode_q;

	logic [2:0] cur_w;
	logic in_ev;
	logic [31:0] sh_next;
	logic [5:0] cnt_next;
	mio_op_info_t nxt_info;
	logic op_done;
	logic op_refused;
	logic addr_done;
	logic mode_done;
	logic [31:0] addr_val;
	mio_state_t after_mode;

	// Mode byte keeps the address lane width and rate
	assign cur_w = (st_q == mio_st_cmd) ? (cfg.quad_command_mode ? 3'h4 : 3'h1)
		: info_q.addr_lanes;
	// A fall with nothing counted yet still belongs to the opcode's last clock
	assign in_ev = rise || (info_q.dtr && fall && st_q != mio_st_cmd
		&& cnt_q != 6'h00);
	assign cnt_next = cnt_q + {3'h0, cur_w};
	assign nxt_info = op_info(sh_next[7:0], cfg.four_byte_mode);
	assign op_done = st_q == mio_st_cmd && rise && cnt_next == `MIO_OPCODE_BITS;
	assign addr_done = st_q == mio_st_addr && in_ev && cnt_next == info_q.addr_bits;
	assign mode_done = st_q == mio_st_mode && in_ev && cnt_next == `MIO_MODE_BITS;
	assign addr_val = (info_q.addr_bits == `MIO_ADDR_WIDE) ? sh_next
		: {8'h00, sh_next[23:0]};
	assign after_mode = (info_q.dummy == 6'h00) ? mio_st_data : mio_st_dummy;

	always_comb begin
		case (cur_w)
			3'h4: sh_next = {sh_q[27:0], s_io};
			3'h2: sh_next = {sh_q[29:0], s_io[1:0]};
			default: sh_next = {sh_q[30:0], s_io[0]};
		endcase
	end

	// Only the quad I/O read is taken while in quad command mode
	always_comb begin
		op_refused = !nxt_info.valid;
		if (cfg.quad_command_mode && sh_next[7:0] == `MIO_OP_QO_W32) begin
			op_refused = 1'b1;
		end
		if (cfg.quad_command_mode && sh_next[7:0] == `MIO_OP_DIO_W32) begin
			op_refused = 1'b1;
		end
		if (cfg.quad_command_mode && sh_next[7:0] != `MIO_OP_QIO) begin
			op_refused = 1'b1;
		end
		if (sh_next[7:0] == `MIO_OP_QIO && !cfg.quad_lane_enable_bit) begin
			op_refused = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= mio_st_idle;
			cnt_q <= 6'h00;
			sh_q <= 32'h0000_0000;
			op_q <= 8'h00;
			info_q <= '0;
			mode_q <= 8'h00;
		end else if (s_cs_n) begin
			st_q <= mio_st_idle;
			cnt_q <= 6'h00;
		end else begin
			case (st_q)
				mio_st_idle: begin
					if (cs_fall) begin
						cnt_q <= 6'h00;
						if (continuous_read_q) begin
							info_q <= op_info(op_q, cfg.four_byte_mode);
							st_q <= mio_st_addr;
						end else begin
							st_q <= mio_st_cmd;
						end
					end
				end
				mio_st_cmd: begin
					if (rise) begin
						sh_q <= sh_next;
						cnt_q <= cnt_next;
						if (op_done) begin
							op_q <= sh_next[7:0];
							info_q <= nxt_info;
							cnt_q <= 6'h00;
							st_q <= op_refused ? mio_st_ignore : mio_st_addr;
						end
					end
				end
				mio_st_addr: begin
					if (in_ev) begin
						sh_q <= sh_next;
						cnt_q <= cnt_next;
						if (addr_done) begin
							cnt_q <= 6'h00;
							st_q <= info_q.has_mode ? mio_st_mode : after_mode;
						end
					end
				end
				mio_st_mode: begin
					if (in_ev) begin
						sh_q <= sh_next;
						cnt_q <= cnt_next;
						if (mode_done) begin
							mode_q <= sh_next[7:0];
							cnt_q <= 6'h00;
							st_q <= after_mode;
						end
					end
				end
				mio_st_dummy: begin
					// Lanes are not sampled while the dummy clocks run
					if (rise) begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q + 6'h01 == info_q.dummy) begin
							cnt_q <= 6'h00;
							st_q <= mio_st_data;
						end
					end
				end
				mio_st_data, mio_st_ignore: begin
					st_q <= st_q;
				end
				default: begin
					st_q <= mio_st_ignore;
				end
			endcase
		end
	end

	// ==========================================================
	// Continuous read flag
	// Only the select bits matter; a host driving ones sets the low
	// select bit and so falls back to full commands
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			continuous_read_q <= 1'b0;
		end else if (mode_done) begin
			continuous_read_q <= sh_next[`MIO_CONT_SEL_MSB:`MIO_CONT_SEL_LSB]
				== `MIO_CONT_SEL;
		end
	end

	// ==========================================================
	// Data prefetch from the array
	logic run_q;
	logic pend_q;
	logic stale_q;
	logic issue;
	logic accept;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;

	// One request in flight, so a free slot always awaits its answer
	assign issue = run_q && !pend_q && fifo_in_ready && !s_cs_n;
	assign accept = arr_valid && pend_q && !stale_q && !s_cs_n;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run_q <= 1'b0;
			pend_q <= 1'b0;
			stale_q <= 1'b0;
			fetch_req_q <= 1'b0;
			fetch_addr_q <= 32'h0000_0000;
		end else begin
			fetch_req_q <= issue && !addr_done;
			if (s_cs_n) begin
				run_q <= 1'b0;
			end else if (addr_done) begin
				run_q <= 1'b1;
			end
			if (issue && !addr_done) begin
				pend_q <= 1'b1;
			end else if (arr_valid) begin
				pend_q <= 1'b0;
			end
			// Answer to a request from a closed frame is dropped
			if (arr_valid) begin
				stale_q <= 1'b0;
			end else if (s_cs_n && pend_q) begin
				stale_q <= 1'b1;
			end
			if (addr_done) begin
				fetch_addr_q <= addr_val;
			end else if (accept) begin
				fetch_addr_q <= fetch_addr_q + 32'h0000_0001;
			end
		end
	end

	mio_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.flush(s_cs_n),
		.in_valid(accept),
		.in_ready(fifo_in_ready),
		.in_data(arr_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// ==========================================================
	// Data output on the lanes
	logic out_ev;
	logic [2:0] left_q;
	logic [7:0] dout_q;
	logic [7:0] byte_now;

	assign out_ev = st_q == mio_st_data && !s_cs_n && (fall || (info_q.dtr && rise));
	assign fifo_pop = out_ev && left_q == 3'h0;
	assign byte_now = fifo_out_valid ? fifo_out_data : `MIO_UNDERRUN_BYTE;

	always_ff @(posedge ref_clk) begin
		if (reset || s_cs_n) begin
			left_q <= 3'h0;
			dout_q <= 8'h00;
			data_lane_out_q <= 4'h0;
			data_lane_oe_q <= 4'h0;
		end else if (st_q != mio_st_data) begin
			data_lane_oe_q <= 4'h0;
		end else if (out_ev) begin
			// Lanes turn round only at the first data edge
			data_lane_oe_q <= (info_q.data_lanes == 3'h4) ? 4'hf : 4'h3;
			if (left_q == 3'h0) begin
				data_lane_out_q <= lanes_of(byte_now, info_q.data_lanes);
				dout_q <= byte_now << info_q.data_lanes;
				left_q <= 3'h0 - info_q.data_lanes;
			end else begin
				data_lane_out_q <= lanes_of(dout_q, info_q.data_lanes);
				dout_q <= dout_q << info_q.data_lanes;
				left_q <= left_q - info_q.data_lanes;
			end
		end
	end

	// ==========================================================
	// Status
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reject_q <= 1'b0;
			busy_q <= 1'b0;
			underrun_q <= 1'b0;
		end else begin
			reject_q <= op_done && op_refused && !s_cs_n;
			busy_q <= !s_cs_n && st_q != mio_st_idle;
			underrun_q <= fifo_pop && !fifo_out_valid && !s_cs_n;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_qo_wide_addr: assert property (st_q == mio_st_addr && op_q == `MIO_OP_QO_W32
		|-> info_q.addr_bits == 6'h20) else $error("6Ch address not 32 bits");
	a_qo_qpi_refuse: assert property (op_done && !s_cs_n && cfg.quad_command_mode
		&& sh_next[7:0] == `MIO_OP_QO_W32 |=> st_q == mio_st_ignore && reject_q)
		else $error("6Ch taken in quad command mode");
	a_dual_addr_lanes: assert property (st_q == mio_st_addr && op_q == `MIO_OP_DIO
		|-> cur_w == 3'h2) else $error("Dual address not two bits per clock");
	a_dummy_no_drive: assert property (st_q == mio_st_dummy
		|-> data_lane_oe_q == 4'h0) else $error("Lanes driven during dummy clocks");
	a_cont_skip_op: assert property (cs_fall && continuous_read_q && st_q == mio_st_idle
		|=> st_q == mio_st_addr) else $error("Continuous frame did not skip opcode");
	a_full_cmd: assert property (cs_fall && !continuous_read_q && st_q == mio_st_idle
		|=> st_q == mio_st_cmd) else $error("Opcode not required");
	a_mode_select: assert property (mode_done |=> continuous_read_q ==
		($past(sh_next[5]) && !$past(sh_next[4]))) else $error("Select bits mishandled");
	a_bc_wide_addr: assert property (st_q == mio_st_addr && op_q == `MIO_OP_DIO_W32
		|-> info_q.addr_bits == 6'h20) else $error("BCh address not 32 bits");
	a_bc_qpi_refuse: assert property (op_done && !s_cs_n && cfg.quad_command_mode
		&& sh_next[7:0] == `MIO_OP_DIO_W32 |=> reject_q) else $error("BCh not refused");
	a_qe_refuse: assert property (op_done && !s_cs_n && !cfg.quad_lane_enable_bit
		&& sh_next[7:0] == `MIO_OP_QIO |=> reject_q && st_q == mio_st_ignore)
		else $error("Quad I/O taken without lane enable");
	a_addr_narrow: assert property (st_q == mio_st_addr && op_q == `MIO_OP_QIO
		&& !cfg.four_byte_mode && $stable(cfg) |-> info_q.addr_bits == 6'h18)
		else $error("Narrow address width wrong");
	a_addr_advance: assert property (accept && !addr_done
		|=> fetch_addr_q == $past(fetch_addr_q) + 32'h0000_0001)
		else $error("Read address did not advance");
	a_msb_lane_hi: assert property (fifo_pop && fifo_out_valid && info_q.data_lanes == 3'h4
		|=> data_lane_out_q == $past(fifo_out_data[7:4])) else $error("Upper nibble not first");

	c_quad_io_data: cover property (st_q == mio_st_data && op_q == `MIO_OP_QIO && out_ev);
	c_cont_frame: cover property (cs_fall && continuous_read_q);
	c_dtr_data: cover property (out_ev && info_q.dtr && rise);
	c_refused: cover property (reject_q);
endmodule : mio_read_seq

// ===== rtl/mio_sync.sv
`timescale 1ns/10ps

module mio_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : mio_sync
